// File: rtl/apm_pkg.sv
// Package for the audio chip power manager: offsets, codes, counts and types
package apm_pkg;

    // ==========================================================
    // Host I/O ports
    localparam logic [11:0] APM_PWR_CTL_ADDR = 12'h227; // power_control_port
    localparam logic [11:0] APM_ACT_FLAG_ADDR = 12'h226; // activity-flag port
    localparam logic [7:0] APM_PORT_HI = 8'h22; // device ports are 0x220..0x22f

    // ==========================================================
    // power_control_port fields
    localparam int APM_PC_GPO_A = 0;
    localparam int APM_PC_GPO_B = 1;
    localparam int APM_PC_PD_REQ = 2;
    localparam int APM_PC_ANALOG_ON = 3;
    localparam int APM_PC_RSVD = 4;
    localparam int APM_PC_FM_RESET = 5;
    localparam int APM_PC_UNKNOWN = 6;
    localparam int APM_PC_SUSPEND = 7;
    localparam logic [7:0] APM_PC_RESET = 8'h02;

    // ==========================================================
    // output_powerdown_control fields
    localparam int APM_OC_CODE_LSB = 0;
    localparam int APM_OC_CODE_W = 3;
    localparam int APM_OC_INV_A = 4;
    localparam int APM_OC_TIMED_A = 5;
    localparam int APM_OC_INV_B = 6;
    localparam int APM_OC_TIMED_B = 7;
    localparam logic [7:0] APM_OC_RESET = 8'h00;

    // ==========================================================
    // Command codes
    localparam logic [7:0] APM_CMD_UNLOCK = 8'hc6;
    localparam logic [7:0] APM_CMD_TIMEOUT = 8'hbd;
    localparam logic [7:0] APM_CMD_RELOCK = 8'hc7;
    localparam logic [7:0] APM_CMD_DOWNLOAD = 8'hc1;
    localparam logic [7:0] APM_CMD_OC_WRITE = 8'hcf;
    localparam logic [7:0] APM_CMD_OC_READ = 8'hce;

    // ==========================================================
    // Timing
    localparam int APM_CLK_HZ = 20000000;
    localparam int APM_TICK_HZ = 16; // restore counter rate
    localparam int APM_TICK_CYCLES = APM_CLK_HZ / APM_TICK_HZ;
    localparam int APM_STEP_S = 8; // seconds per timeout unit
    localparam int APM_STEP_TICKS = APM_STEP_S * APM_TICK_HZ;
    localparam logic [9:0] APM_CTX_BYTES = 10'h30e; // 782 context bytes

    // ==========================================================
    // Types
    typedef enum logic [1:0] {APM_PWR_ON, APM_PWR_PARTIAL, APM_PWR_FULL} apm_pwr_t;
    typedef enum logic [1:0] {APM_CP_IDLE, APM_CP_TIMEOUT_ARG, APM_CP_OC_ARG} apm_cp_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } apm_io_t;

    typedef struct packed {
        logic full;
        logic partial;
        logic osc_run;
        logic analog_on;
        logic synth_mute;
        logic dac_mute;
    } apm_pwr_status_t;

endpackage

// File: rtl/apm_power_manager.sv
// Power manager of a PC audio chip: control port, power states, timers, outputs
//
// Overview of operation
// - Control port access never wakes the device
// - Bit zero drives output A, resets low
// - Bit one drives output B, resets high
// - Power-down bit rising edge interrupts processor
// - Analog bit selects partial or full power-down
// - Bit five holds synthesizer in reset
// - Suspend pulse interrupts processor, starts upload
// - Timeout is byte times eight seconds
// - Explicit power-down works with timer enabled
// - Inactivity timer runs only between finished commands
// - Saved context is 782 bytes both ways
// - Output control written, read by commands; soft-reset-proof
// - Invert bits flip outputs during full power-down
// - Timed bits delay restoring outputs after wake
// - Restore delay counts 16 Hz up to code
// - Partial keeps oscillator, analog; mutes synth, DAC
// - Other device port access, except the activity flag port, wakes device
`timescale 1ns/1ns
`default_nettype none

module apm_power_manager
    import apm_pkg::*;
#(
    parameter int TICK_CYCLES = APM_TICK_CYCLES
)
(
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire apm_io_t io_in,
    input wire logic dma_ack_in,
    input wire logic soft_reset_in,
    input wire logic cmd_wr_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic op_busy_in,
    input wire logic ctx_strobe_in,
    output logic [7:0] io_rdata_out,
    output logic [7:0] cmd_resp_out,
    output logic cmd_resp_valid_out,
    output logic general_output_a_out,
    output logic general_output_b_out,
    output logic fm_reset_out,
    output logic pd_irq_out,
    output logic suspend_irq_out,
    output apm_pwr_status_t pwr_status_out,
    output logic ctx_upload_out,
    output logic ctx_download_out,
    output logic [9:0] ctx_count_out
);

    // ==========================================================
    // Register state
    logic [7:0] pc_q, pc_d;
    logic [7:0] oc_q, oc_d;
    apm_pwr_t pwr_q, pwr_d;
    apm_cp_t cp_q, cp_d;
    logic unlock_q, unlock_d;
    logic [7:0] timeout_q, timeout_d;
    logic [31:0] div_q;
    logic [14:0] idle_q;
    logic [2:0] rst_cnt_q;
    logic pend_q;
    logic up_q, down_q;
    logic [9:0] ctx_q;
    logic [7:0] resp_q;
    logic resp_v_q;
    logic pdirq_q, susirq_q;

    // ==========================================================
    // Host port decode
    wire logic io_any = io_in.wr | io_in.rd;
    wire logic pc_wr = io_in.wr && (io_in.addr == APM_PWR_CTL_ADDR);
    wire logic in_range = (io_in.addr[11:4] == APM_PORT_HI);
    // Control and activity ports are excluded so polling never wakes us
    wire logic io_wake = io_any && in_range && (io_in.addr != APM_PWR_CTL_ADDR)
        && (io_in.addr != APM_ACT_FLAG_ADDR);
    wire logic wake = io_wake | dma_ack_in;

    // Request edges: only a low-to-high change of the stored bit counts
    wire logic pd_edge = pc_wr && io_in.wdata[APM_PC_PD_REQ] && !pc_q[APM_PC_PD_REQ];
    wire logic sus_edge = pc_wr && io_in.wdata[APM_PC_SUSPEND] && !pc_q[APM_PC_SUSPEND];

    // Bit six reads as zero, everything else reads back as written
    assign io_rdata_out = pc_q & ~(8'h01 << APM_PC_UNKNOWN);

    // ==========================================================
    // Power control port
    assign pc_d = pc_wr ? io_in.wdata : pc_q;

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            pc_q <= APM_PC_RESET;
        else
            pc_q <= pc_d;
    end

    // ==========================================================
    // 16 Hz tick divider
    wire logic tick = (div_q == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            div_q <= 32'h0;
        else
            div_q <= tick ? 32'h0 : div_q + 32'h1;
    end

    // ==========================================================
    // Command parser: timeout and output-control programming
    wire logic cmd_idle = (cp_q == APM_CP_IDLE);
    wire logic oc_read = cmd_wr_in && cmd_idle && (cmd_byte_in == APM_CMD_OC_READ);
    wire logic dl_start = cmd_wr_in && cmd_idle && (cmd_byte_in == APM_CMD_DOWNLOAD);

    always_comb
    begin
        cp_d = cp_q;
        unlock_d = unlock_q;
        timeout_d = timeout_q;
        oc_d = oc_q;
        if (cmd_wr_in)
        begin
            case (cp_q)
                APM_CP_IDLE:
                begin
                    if (cmd_byte_in == APM_CMD_UNLOCK)
                        unlock_d = 1'b1;
                    else if (cmd_byte_in == APM_CMD_RELOCK)
                        unlock_d = 1'b0;
                    else if (cmd_byte_in == APM_CMD_TIMEOUT && unlock_q)
                        cp_d = APM_CP_TIMEOUT_ARG;
                    else if (cmd_byte_in == APM_CMD_OC_WRITE)
                        cp_d = APM_CP_OC_ARG;
                end
                APM_CP_TIMEOUT_ARG:
                begin
                    timeout_d = cmd_byte_in;
                    cp_d = APM_CP_IDLE;
                end
                APM_CP_OC_ARG:
                begin
                    oc_d = cmd_byte_in;
                    oc_d[3] = 1'b0;
                    cp_d = APM_CP_IDLE;
                end
                default:
                    cp_d = APM_CP_IDLE;
            endcase
        end
    end

    // Soft reset clears the parser but leaves the output control register alone
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cp_q <= APM_CP_IDLE;
            unlock_q <= 1'b0;
            timeout_q <= 8'h00;
        end
        else if (soft_reset_in)
        begin
            cp_q <= APM_CP_IDLE;
            unlock_q <= 1'b0;
            timeout_q <= 8'h00;
        end
        else
        begin
            cp_q <= cp_d;
            unlock_q <= unlock_d;
            timeout_q <= timeout_d;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            oc_q <= APM_OC_RESET;
        else
            oc_q <= oc_d;
    end

    // Read-back answer of the output control register
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            resp_q <= 8'h00;
            resp_v_q <= 1'b0;
        end
        else
        begin
            resp_v_q <= oc_read;
            resp_q <= oc_read ? oc_q : resp_q;
        end
    end

    assign cmd_resp_out = resp_q;
    assign cmd_resp_valid_out = resp_v_q;

    // ==========================================================
    // Inactivity timer, in 16 Hz ticks; 8 s is 128 ticks per unit
    wire logic [14:0] idle_limit = 15'({timeout_q, 7'h0});
    wire logic timer_en = (timeout_q != 8'h00) && (pwr_q == APM_PWR_ON);
    // Stopped while an operation or a multi-byte command is still open
    wire logic timer_run = timer_en && !op_busy_in && cmd_idle;
    wire logic timer_clr = !timer_en || cmd_wr_in || wake || soft_reset_in;
    wire logic self_pd = timer_run && tick && (idle_q == idle_limit - 15'h1);

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            idle_q <= 15'h0;
        else if (timer_clr || self_pd)
            idle_q <= 15'h0;
        else if (timer_run && tick)
            idle_q <= idle_q + 15'h1;
    end

    // ==========================================================
    // Power state machine
    wire logic pd_go = pd_edge | self_pd;
    // The analog bit as written in the same cycle decides the type
    wire logic analog_sel = pc_d[APM_PC_ANALOG_ON];

    always_comb
    begin
        pwr_d = pwr_q;
        case (pwr_q)
            APM_PWR_ON:
            begin
                if (pd_go)
                    pwr_d = analog_sel ? APM_PWR_PARTIAL : APM_PWR_FULL;
            end
            APM_PWR_PARTIAL, APM_PWR_FULL:
            begin
                if (wake)
                    pwr_d = APM_PWR_ON;
                else if (pd_go)
                    pwr_d = analog_sel ? APM_PWR_PARTIAL : APM_PWR_FULL;
            end
            default:
                pwr_d = APM_PWR_ON;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            pwr_q <= APM_PWR_ON;
        else
            pwr_q <= pwr_d;
    end

    // Partial keeps the oscillator and analog up, audio paths muted
    assign pwr_status_out.full = (pwr_q == APM_PWR_FULL);
    assign pwr_status_out.partial = (pwr_q == APM_PWR_PARTIAL);
    assign pwr_status_out.osc_run = (pwr_q != APM_PWR_FULL);
    assign pwr_status_out.analog_on = (pwr_q != APM_PWR_FULL);
    assign pwr_status_out.synth_mute = (pwr_q != APM_PWR_ON);
    assign pwr_status_out.dac_mute = (pwr_q != APM_PWR_ON);

    // ==========================================================
    // Restore delay after waking from full power-down
    wire logic full_wake = (pwr_q == APM_PWR_FULL) && (pwr_d == APM_PWR_ON);
    wire logic [2:0] code = oc_q[APM_OC_CODE_LSB +: APM_OC_CODE_W];
    wire logic rst_done = (rst_cnt_q == code);

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pend_q <= 1'b0;
            rst_cnt_q <= 3'h0;
        end
        else if (full_wake)
        begin
            pend_q <= 1'b1;
            rst_cnt_q <= 3'h0;
        end
        else if (pwr_q != APM_PWR_ON)
            pend_q <= 1'b0;
        else if (pend_q && rst_done)
            pend_q <= 1'b0;
        else if (pend_q && tick)
            rst_cnt_q <= rst_cnt_q + 3'h1;
    end

    // ==========================================================
    // General outputs: programmed level, inverted in full power-down
    wire logic in_full = (pwr_q == APM_PWR_FULL);
    wire logic flip_a = oc_q[APM_OC_INV_A] && (in_full || (pend_q && oc_q[APM_OC_TIMED_A]));
    wire logic flip_b = oc_q[APM_OC_INV_B] && (in_full || (pend_q && oc_q[APM_OC_TIMED_B]));

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            {general_output_a_out, general_output_b_out, fm_reset_out} <= 3'b010;
        else
            {general_output_a_out, general_output_b_out, fm_reset_out} <= {pc_q[APM_PC_GPO_A] ^ flip_a,
                pc_q[APM_PC_GPO_B] ^ flip_b, pc_q[APM_PC_FM_RESET]};
    end

    // ==========================================================
    // Interrupts to the embedded processor, one pulse per edge
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            {pdirq_q, susirq_q} <= 2'b00;
        else
            {pdirq_q, susirq_q} <= {pd_edge, sus_edge};
    end

    assign pd_irq_out = pdirq_q;
    assign suspend_irq_out = susirq_q;

    // ==========================================================
    // Context transfer byte count; suspend starts upload, command starts download
    wire logic ctx_last = (ctx_q == APM_CTX_BYTES - 10'h1);

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            up_q <= 1'b0;
            down_q <= 1'b0;
            ctx_q <= 10'h0;
        end
        else if (sus_edge && !down_q)
        begin
            up_q <= 1'b1;
            ctx_q <= 10'h0;
        end
        else if (dl_start && !up_q)
        begin
            down_q <= 1'b1;
            ctx_q <= 10'h0;
        end
        else if ((up_q || down_q) && ctx_strobe_in)
        begin
            ctx_q <= ctx_q + 10'h1;
            if (ctx_last)
                {up_q, down_q} <= 2'b00;
        end
    end

    assign ctx_upload_out = up_q;
    assign ctx_download_out = down_q;
    assign ctx_count_out = ctx_q;

endmodule

`default_nettype wire

// File: verif/apm_host.sv
// Host processor model: I/O cycles on the device ports and command bytes
`timescale 1ns/1ns
`default_nettype none
module apm_host
    import apm_pkg::*;
(
    input wire logic clk_in,
    output apm_io_t io_out,
    output logic cmd_wr_out,
    output logic [7:0] cmd_byte_out
);
    // =========================================
    // Bus cycles
    // One-cycle strobes; released lines show the inverse so stale data never looks valid
    initial
    begin
        io_out = '0;
        cmd_wr_out = 1'b0;
        cmd_byte_out = 8'h00;
    end

    task automatic acc(input logic [11:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_in);
        io_out <= '{addr: a, wdata: d & 8'hef, wr: w, rd: !w};
        @(posedge clk_in);
        io_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // Request pulse: set the bit, then clear it, other bits written back unchanged except bit four, which acc forces low
    task automatic pulse(input logic [7:0] m, input logic [7:0] base);
        acc(APM_PWR_CTL_ADDR, base | m, 1'b1);
        acc(APM_PWR_CTL_ADDR, base, 1'b1);
    endtask

    task automatic cmd(input logic [7:0] b);
        @(posedge clk_in);
        cmd_wr_out <= 1'b1;
        cmd_byte_out <= b;
        @(posedge clk_in);
        cmd_wr_out <= 1'b0;
        cmd_byte_out <= ~b;
    endtask
endmodule
`default_nettype wire

// File: verif/apm_properties.sv
// Concurrent checks on the power manager ports
`timescale 1ns/1ns
`default_nettype none
module apm_properties
    import apm_pkg::*;
#(
    parameter int TICK_CYCLES = APM_TICK_CYCLES
)
(
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire apm_io_t io_in,
    input wire logic dma_ack_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic fm_reset_out,
    input wire logic pd_irq_out,
    input wire logic suspend_irq_out,
    input wire apm_pwr_status_t pwr_status_out
);
    // =========================================
    // Decoded host cycles; rises are judged against the stored port value
    wire logic acc_pc;
    wire logic wr_pc;
    wire logic pd_rise;
    wire logic sus_rise;
    wire logic wake_acc;
    wire logic down;
    assign acc_pc = (io_in.wr || io_in.rd) && io_in.addr == APM_PWR_CTL_ADDR;
    assign wr_pc = io_in.wr && io_in.addr == APM_PWR_CTL_ADDR;
    assign pd_rise = wr_pc && io_in.wdata[APM_PC_PD_REQ] && !io_rdata_out[APM_PC_PD_REQ];
    assign sus_rise = wr_pc && io_in.wdata[APM_PC_SUSPEND] && !io_rdata_out[APM_PC_SUSPEND];
    assign wake_acc = (io_in.wr || io_in.rd) && io_in.addr[11:4] == APM_PORT_HI
        && io_in.addr != APM_ACT_FLAG_ADDR && io_in.addr != APM_PWR_CTL_ADDR;
    assign down = pwr_status_out.full || pwr_status_out.partial;

    // =========================================
    // Assertions
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    a_pd_irq_edge: assert property (pd_rise |=> pd_irq_out)
        else $error("power-down pulse missing");
    a_pd_irq_cause: assert property (pd_irq_out |-> $past(pd_rise))
        else $error("power-down pulse without rising edge");
    a_susp_irq_edge: assert property (sus_rise |=> suspend_irq_out)
        else $error("suspend pulse missing");
    a_susp_irq_cause: assert property (suspend_irq_out |-> $past(sus_rise))
        else $error("suspend pulse without rising edge");
    a_pd_type_sel: assert property (pd_rise |=> pwr_status_out.partial == $past(io_in.wdata[APM_PC_ANALOG_ON])
        && pwr_status_out.full != $past(io_in.wdata[APM_PC_ANALOG_ON]))
        else $error("wrong power-down type");
    a_fm_reset_follow: assert property (wr_pc |-> ##2 fm_reset_out == $past(io_in.wdata[APM_PC_FM_RESET], 2))
        else $error("synth reset does not follow port");
    a_port_no_wake: assert property (down && acc_pc && !io_in.wdata[APM_PC_PD_REQ] && !dma_ack_in
        |=> $stable(pwr_status_out))
        else $error("control port access changed power state");
    a_access_wakes: assert property (down && (wake_acc || dma_ack_in) |=> !down)
        else $error("device access did not wake");
    a_partial_keep: assert property (pwr_status_out.partial |-> pwr_status_out.osc_run
        && pwr_status_out.analog_on && pwr_status_out.synth_mute && pwr_status_out.dac_mute)
        else $error("partial state status wrong");

    c_pd: cover property (pd_rise);
    c_sus: cover property (sus_rise);
    c_partial: cover property (pwr_status_out.partial);
    c_wake: cover property (down && wake_acc);
endmodule

bind apm_power_manager apm_properties #(.TICK_CYCLES(TICK_CYCLES)) u_apm_properties (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .io_in(io_in),
    .dma_ack_in(dma_ack_in),
    .io_rdata_out(io_rdata_out),
    .fm_reset_out(fm_reset_out),
    .pd_irq_out(pd_irq_out),
    .suspend_irq_out(suspend_irq_out),
    .pwr_status_out(pwr_status_out)
);
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking testbench for the power manager
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import apm_pkg::*;
;
    // Short tick keeps the 16 Hz and 8 s counts small
    localparam int TC = 4;
    // Soft reset must be released 1 ms (20000 cycles) before a power-down request
    localparam int SRST_WAIT = 20000;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic dma, srst, busy, stb, cw, rv, ga, gb, fm, pdi, si, up, dn;
    apm_io_t io;
    logic [7:0] cb, rdata, resp;
    logic [9:0] cnt;
    apm_pwr_status_t st;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;

    apm_host u_apm_host (.clk_in(clk_sys_in), .io_out(io), .cmd_wr_out(cw), .cmd_byte_out(cb));
    apm_power_manager #(.TICK_CYCLES(TC)) u_apm_power_manager (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .io_in(io), .dma_ack_in(dma),
        .soft_reset_in(srst), .cmd_wr_in(cw), .cmd_byte_in(cb), .op_busy_in(busy),
        .ctx_strobe_in(stb), .io_rdata_out(rdata), .cmd_resp_out(resp), .cmd_resp_valid_out(rv),
        .general_output_a_out(ga), .general_output_b_out(gb), .fm_reset_out(fm),
        .pd_irq_out(pdi), .suspend_irq_out(si), .pwr_status_out(st), .ctx_upload_out(up),
        .ctx_download_out(dn), .ctx_count_out(cnt));

    // =========================================
    // Clock, watchdog and shared tasks
    initial
    begin
        forever #25 clk_sys_in = !clk_sys_in;
    end

    // A hang counts as a mismatch
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            final_report;
        end
    end

    task automatic final_report;
        $display("Errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] d);
        u_apm_host.acc(APM_PWR_CTL_ADDR, d, 1'b1);
    endtask

    task automatic wake;
        u_apm_host.acc(12'h222, 8'h00, 1'b0);
        #1;
    endtask

    task automatic rd_oc(input logic [7:0] e);
        int i;
        u_apm_host.cmd(APM_CMD_OC_READ);
        #1;
        for (i = 0; i < 4 && rv !== 1'b1; i++)
            w(1);
        chk(10'(rv), 10'h1);
        chk(10'(resp), 10'(e));
    endtask

    task automatic strobe(input int n);
        repeat (n)
        begin
            @(posedge clk_sys_in);
            stb <= 1'b1;
        end
        @(posedge clk_sys_in);
        stb <= 1'b0;
    endtask

    // =========================================
    // Scenarios
    task automatic t_reset;
        chk(10'(rdata), 10'h2);
        chk(10'({ga, gb, fm, st.full, st.partial}), 10'h8);
        rd_oc(APM_OC_RESET);
    endtask

    // Bit six is written high but must read back low
    task automatic t_out;
        wr(8'h61);
        w(1);
        chk(10'({ga, gb, fm}), 10'h5);
        chk(10'(rdata), 10'h21);
        wr(8'h02);
        w(1);
        chk(10'({ga, gb, fm}), 10'h2);
    endtask

    task automatic t_full;
        wr(8'h06);
        #1;
        chk(10'({pdi, st.full, st.partial, st.osc_run, st.analog_on}), 10'h18);
        w(1);
        chk(10'(pdi), 10'h0);
        u_apm_host.acc(APM_PWR_CTL_ADDR, 8'h00, 1'b0);
        u_apm_host.acc(APM_ACT_FLAG_ADDR, 8'h00, 1'b0);
        #1;
        chk(10'(st.full), 10'h1);
        wake;
        chk(10'(st.full), 10'h0);
        wr(8'h06);
        #1;
        chk(10'({pdi, st.full}), 10'h0);
        wr(8'h02);
    endtask

    task automatic t_partial;
        u_apm_host.pulse(8'h04, 8'h0a);
        #1;
        chk(10'({st.full, st.partial, st.osc_run, st.analog_on, st.synth_mute, st.dac_mute}), 10'h1f);
        @(posedge clk_sys_in);
        dma <= 1'b1;
        @(posedge clk_sys_in);
        dma <= 1'b0;
        #1;
        chk(10'(st.partial), 10'h0);
    endtask

    task automatic t_gpo;
        u_apm_host.cmd(APM_CMD_OC_WRITE);
        u_apm_host.cmd(8'h50);
        rd_oc(8'h50);
        u_apm_host.pulse(8'h04, 8'h03);
        w(1);
        chk(10'({ga, gb}), 10'h0);
        wake;
        w(2);
        chk(10'({ga, gb}), 10'h3);
        u_apm_host.cmd(APM_CMD_OC_WRITE);
        u_apm_host.cmd(8'hf3);
        u_apm_host.pulse(8'h04, 8'h03);
        wake;
        w(2);
        chk(10'({ga, gb}), 10'h0);
        w(16);
        chk(10'({ga, gb}), 10'h3);
        @(posedge clk_sys_in);
        srst <= 1'b1;
        @(posedge clk_sys_in);
        srst <= 1'b0;
        w(SRST_WAIT);
        rd_oc(8'hf3);
    endtask

    // Upload by suspend pulse, then download by command
    task automatic t_ctx;
        int k;
        for (k = 0; k < 2; k++)
        begin
            // Suspend pulse by hand so the one-cycle interrupt can be seen
            if (k == 0)
            begin
                wr(8'h83);
                #1;
                chk(10'(si), 10'h1);
                wr(8'h03);
            end
            else
            begin
                // Resume needs a hardware reset before the download command
                @(posedge clk_sys_in);
                reset_in <= 1'b1;
                repeat (2) @(posedge clk_sys_in);
                reset_in <= 1'b0;
                w(1);
                chk(10'(rdata), 10'h2);
                u_apm_host.cmd(APM_CMD_DOWNLOAD);
            end
            w(1);
            chk(10'(k ? dn : up), 10'h1);
            strobe(781);
            w(1);
            chk(cnt, 10'd781);
            strobe(1);
            w(2);
            chk(10'({up, dn}), 10'h0);
        end
    endtask

    // One unit is 128 ticks of TC cycles; a busy operation halts the count
    task automatic t_timer;
        int n;
        u_apm_host.cmd(APM_CMD_UNLOCK);
        u_apm_host.cmd(APM_CMD_TIMEOUT);
        u_apm_host.cmd(8'h01);
        u_apm_host.cmd(APM_CMD_RELOCK);
        @(posedge clk_sys_in);
        busy <= 1'b1;
        w(700);
        chk(10'(st.full), 10'h0);
        @(posedge clk_sys_in);
        busy <= 1'b0;
        for (n = 0; n < 700 && st.full !== 1'b1; n++)
            w(1);
        chk(10'(n >= 500 && n <= 520), 10'h1);
        wake;
        u_apm_host.pulse(8'h04, 8'h03);
        #1;
        chk(10'(st.full), 10'h1);
        wake;
        u_apm_host.cmd(APM_CMD_UNLOCK);
        u_apm_host.cmd(APM_CMD_TIMEOUT);
        u_apm_host.cmd(8'h00);
        u_apm_host.cmd(APM_CMD_RELOCK);
        w(700);
        chk(10'(st.full), 10'h0);
    endtask

    // =========================================
    // Main sequence
    initial
    begin
        dma = 1'b0;
        srst = 1'b0;
        busy = 1'b0;
        stb = 1'b0;
        repeat (12) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        w(1);
        t_reset;
        t_out;
        t_full;
        t_partial;
        t_gpo;
        t_ctx;
        t_timer;
        final_report;
    end
endmodule
`default_nettype wire
